// ==== inc/irap_pkg.sv ====
// Operation
// - Every control register is eight bits, reached only by index then data.
// - Two I/O addresses only: index port 3E0h, data port 3E1h.
// - External decode: outside logic decodes address; accesses qualified by chip select.
// - Interrupt pin sampled at reset drive fall: high internal, low external decode.
// - Index bit7 is device, bit6 is slot, low six bits pick the register.
// - Fifty-six control registers for each card slot.
// - Device bit strapped: speaker pin on two-slot, ring pin on one-slot variant.
// - One-slot variant straps its slot bit from the speaker pin.
// - Strap high gives 0, ground gives 1; claimed ranges 00-3F, 40-7F, 80-BF, C0-EF.
// - Unclaimed index ranges ignored; index read there leaves data bus floating.
// - Bit0 of register 1Fh puts the slot in ATA mode; clear is normal.
// - ATA with lamp enable: card speaker in drives open-drain IRQ12; speaker quiet.
// - ATA mode drives card address 21 to 25 from bits 2 to 6.
// - Bit7 of register 1Fh stops data bus drive on reads of 3F7h, 377h.
// - One power-down bit, writable via either slot's global control index.
// - In power-down the bus data, address, strobes and enables are ignored.
package irap_pkg;

   // Host I/O addresses
   localparam logic [15:0] IRAP_IO_INDEX     = 16'h03E0;
   localparam logic [15:0] IRAP_IO_DATA      = 16'h03E1;
   localparam logic [15:0] IRAP_IO_FLOPPY_A  = 16'h03F7;
   localparam logic [15:0] IRAP_IO_FLOPPY_B  = 16'h0377;

   // Index layout and register map
   localparam int          IRAP_NUM_REGS     = 56;
   localparam logic [5:0]  IRAP_NUM_REGS_W   = 6'h38;
   localparam int          IRAP_DEV_POS      = 7;
   localparam int          IRAP_SLOT_POS     = 6;
   localparam logic [1:0]  IRAP_TOP_RANGE    = 2'h3;
   localparam logic [1:0]  IRAP_TOP_HOLE     = 2'h3;
   localparam logic [5:0]  IRAP_IDX_GLOBAL   = 6'h1E;
   localparam logic [5:0]  IRAP_IDX_ATA      = 6'h1F;

   // Field positions
   localparam int          IRAP_PD_BIT       = 0;
   localparam int          IRAP_ATA_BIT      = 0;
   localparam int          IRAP_LAMP_BIT     = 1;
   localparam int          IRAP_CAHI_LSB     = 2;
   localparam int          IRAP_CAHI_MSB     = 6;
   localparam int          IRAP_FLOPPY_BIT   = 7;

   // Values after reset
   localparam logic [7:0]  IRAP_REG_RESET    = 8'h00;
   localparam logic [7:0]  IRAP_INDEX_RESET  = 8'h00;
   localparam logic        IRAP_PD_RESET     = 1'b0;
   localparam logic        IRAP_INT_DEC_RST  = 1'b1;

   typedef enum logic [2:0] {
      IRAP_ST_IDLE  = 3'b001,
      IRAP_ST_READ  = 3'b010,
      IRAP_ST_WRITE = 3'b100
   } irap_state_t;

endpackage

// ==== src/irap_strap_latch.sv ====
`timescale 1ns/1ps
`default_nettype none
module irap_strap_latch
   import irap_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   input  wire logic i_resetdrv,
   input  wire logic i_system_mgmt_interrupt_out_pin,
   input  wire logic i_spkr_pin,
   input  wire logic i_ring_pin,
   input  wire logic i_one_slot,
   output logic      o_int_decode,
   output logic      o_dev_bit,
   output logic      o_slot_bit
);

   typedef struct packed {
      logic rdrv;
      logic int_decode;
      logic dev_bit;
      logic slot_bit;
   } irap_strap_t;

   irap_strap_t r;
   irap_strap_t n;

   // Straps are caught at the reset drive fall, not under reset, so no
   // flip-flop ever loads a pin level asynchronously
   always_comb begin
      n = r;
      n.rdrv = i_resetdrv;
      if (r.rdrv && !i_resetdrv) begin
         n.int_decode = i_system_mgmt_interrupt_out_pin;
         n.dev_bit    = i_one_slot ? !i_ring_pin : !i_spkr_pin;
         n.slot_bit   = i_one_slot ? !i_spkr_pin : 1'b0;
      end
   end

   // Mode strap resets to internal decode so a missing fall still answers 3E0h
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         r <= '{rdrv: 1'b0, int_decode: IRAP_INT_DEC_RST, dev_bit: 1'b0, slot_bit: 1'b0};
      end else begin
         r <= n;
      end
   end

   assign o_int_decode = r.int_decode;
   assign o_dev_bit    = r.dev_bit;
   assign o_slot_bit   = r.slot_bit;

   // Mode strap follows the interrupt pin level at the fall
   a_strap_mode: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (r.rdrv && !i_resetdrv) |=> (o_int_decode == $past(i_system_mgmt_interrupt_out_pin)))
      else $error("decode mode strap not taken at reset drive fall");

   // Device bit is the inverse of its strap; a tied-high pin gives device 0
   a_strap_device: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (r.rdrv && !i_resetdrv && !i_one_slot) |=> (o_dev_bit != $past(i_spkr_pin)))
      else $error("device strap not taken at reset drive fall");

endmodule
`default_nettype wire

// ==== src/irap_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module irap_top
   import irap_pkg::*;
#(
   parameter logic P_ONE_SLOT = 1'b0
)(
   input  wire logic             i_clk,
   input  wire logic             i_rst_b,
   input  wire logic             i_resetdrv,
   input  wire logic [15:0]      i_sa,
   input  wire logic [7:0]       i_sd,
   input  wire logic             i_iord_b,
   input  wire logic             i_iowr_b,
   input  wire logic             i_aen,
   input  wire logic             i_cs_b,
   input  wire logic [1:0]       i_card_io_hit,
   input  wire logic [7:0]       i_card_rd_data,
   input  wire logic [1:0][4:0]  i_map_ca_hi,
   input  wire logic [1:0]       i_card_spkr_b,
   input  wire logic             i_system_mgmt_interrupt_out_b,
   input  wire logic             i_speaker_out_pin_b,
   input  wire logic             i_ring_indicate_out_pin_b,
   output logic [7:0]            o_sd,
   output logic                  o_sd_oe,
   output logic                  o_system_mgmt_interrupt_out_b,
   output logic                  o_system_mgmt_interrupt_out_oe,
   output logic                  o_speaker_out_pin_b,
   output logic                  o_speaker_out_pin_oe,
   output logic                  o_ring_indicate_out_pin_b,
   output logic                  o_ring_indicate_out_pin_oe,
   output logic                  o_irq12_lamp,
   output logic                  o_irq12_lamp_oe,
   output logic [1:0][4:0]       o_card_addr_hi,
   output logic [1:0]            o_ata_mode,
   output logic                  o_power_down
);

   typedef struct packed {
      irap_state_t                               st;
      logic [7:0]                                index;
      logic                                      power_down;
      logic [1:0][IRAP_NUM_REGS-1:0][7:0]        regs;
      logic [7:0]                                sd_out;
      logic                                      sd_oe;
      logic                                      lamp_oe;
      logic                                      spk_out;
      logic                                      strap_oe;
      logic                                      idle_high;
      logic [1:0][4:0]                           ca_hi;
      logic [1:0]                                ata;
   } irap_core_t;

   irap_core_t r;
   irap_core_t n;

   logic       int_decode;
   logic       dev_bit;
   logic       slot_bit;
   logic       io_sel;
   logic       is_data;
   logic       claim;
   logic       reg_ok;
   logic       slot;
   logic [5:0] reg_no;
   logic [7:0] rd_val;
   logic       floppy_addr;
   logic [1:0] card_keep;
   logic       card_drive;
   logic [1:0] ata_en;
   logic [1:0] lamp_mode;
   logic       wr_start;
   logic       rd_start;

   // Straps are latched at the reset drive fall in their own small block
   irap_strap_latch u_strap (
      .i_clk        (i_clk),
      .i_rst_b      (i_rst_b),
      .i_resetdrv   (i_resetdrv),
      .i_system_mgmt_interrupt_out_pin   (i_system_mgmt_interrupt_out_b),
      .i_spkr_pin   (i_speaker_out_pin_b),
      .i_ring_pin   (i_ring_indicate_out_pin_b),
      .i_one_slot   (P_ONE_SLOT),
      .o_int_decode (int_decode),
      .o_dev_bit    (dev_bit),
      .o_slot_bit   (slot_bit)
   );

   // Port decode: internal mode matches both addresses, external trusts chip select
   always_comb begin
      if (int_decode) begin
         io_sel = !i_cs_b && !i_aen &&
                  ((i_sa == IRAP_IO_INDEX) || (i_sa == IRAP_IO_DATA));
      end else begin
         io_sel = !i_cs_b;
      end
      is_data = i_sa[0];
   end

   // Index claim: device bit, slot bit on the one-slot part, and the EF top
   always_comb begin
      reg_no = r.index[5:0];
      slot   = P_ONE_SLOT ? 1'b0 : r.index[IRAP_SLOT_POS];
      claim  = (r.index[IRAP_DEV_POS] == dev_bit) &&
               (!P_ONE_SLOT || (r.index[IRAP_SLOT_POS] == slot_bit)) &&
               !((r.index[7:6] == IRAP_TOP_RANGE) && (r.index[5:4] == IRAP_TOP_HOLE));
      reg_ok = reg_no < IRAP_NUM_REGS_W;
      rd_val = 8'h00;
      if (reg_ok) begin
         rd_val = r.regs[slot][reg_no];
         if (reg_no == IRAP_IDX_GLOBAL) begin
            rd_val[IRAP_PD_BIT] = r.power_down;
         end
      end
   end

   // Per-slot mode decode from register 1Fh
   always_comb begin
      for (int s = 0; s < 2; s++) begin
         ata_en[s]    = r.regs[s][IRAP_IDX_ATA][IRAP_ATA_BIT];
         lamp_mode[s] = ata_en[s] && r.regs[s][IRAP_IDX_ATA][IRAP_LAMP_BIT];
         card_keep[s] = i_card_io_hit[s] &&
                        !(floppy_addr && r.regs[s][IRAP_IDX_ATA][IRAP_FLOPPY_BIT]);
      end
   end

   // Floppy addresses stay free when 1Fh bit7 is set, so the board floppy controller owns them
   assign floppy_addr = (i_sa == IRAP_IO_FLOPPY_A) || (i_sa == IRAP_IO_FLOPPY_B);
   assign card_drive  = |card_keep && !i_iord_b;
   assign wr_start    = (r.st == IRAP_ST_IDLE) && !r.power_down && io_sel && !i_iowr_b;
   assign rd_start    = (r.st == IRAP_ST_IDLE) && !r.power_down && io_sel && !i_iord_b
                        && i_iowr_b;

   // Next state: one write per strobe, read data held until strobe release
   always_comb begin
      n = r;
      n.strap_oe  = !i_resetdrv;
      n.idle_high = 1'b1;
      unique case (r.st)
         IRAP_ST_IDLE: begin
            n.sd_oe = 1'b0;
            if (wr_start) begin
               n.st = IRAP_ST_WRITE;
               if (!is_data) begin
                  n.index = i_sd;
               end else if (claim && reg_ok) begin
                  n.regs[slot][reg_no] = i_sd;
                  if (reg_no == IRAP_IDX_GLOBAL) begin
                     n.power_down = i_sd[IRAP_PD_BIT];
                  end
               end
            end else if (rd_start) begin
               n.st     = IRAP_ST_READ;
               n.sd_oe  = claim;
               n.sd_out = is_data ? rd_val : r.index;
            end else if (!r.power_down && card_drive) begin
               n.sd_oe  = 1'b1;
               n.sd_out = i_card_rd_data;
            end
         end
         IRAP_ST_READ: begin
            if (i_iord_b) begin
               n.st    = IRAP_ST_IDLE;
               n.sd_oe = 1'b0;
            end
         end
         IRAP_ST_WRITE: begin
            if (i_iowr_b) begin
               n.st = IRAP_ST_IDLE;
            end
         end
         default: begin
            n.st    = IRAP_ST_IDLE;
            n.sd_oe = 1'b0;
         end
      endcase
      // Power-down freezes the bus side; only a reset brings it back
      if (r.power_down) begin
         n.st    = IRAP_ST_IDLE;
         n.sd_oe = 1'b0;
      end
      // Card side outputs
      for (int s = 0; s < 2; s++) begin
         n.ata[s]   = ata_en[s];
         n.ca_hi[s] = ata_en[s] ?
                      r.regs[s][IRAP_IDX_ATA][IRAP_CAHI_MSB:IRAP_CAHI_LSB] :
                      i_map_ca_hi[s];
      end
      n.lamp_oe = |(lamp_mode & ~i_card_spkr_b);
      n.spk_out = &(i_card_spkr_b | lamp_mode);
   end

   // State register; everything the host can see restarts from package values
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         r            <= '0;
         r.st         <= IRAP_ST_IDLE;
         r.index      <= IRAP_INDEX_RESET;
         r.power_down <= IRAP_PD_RESET;
         r.regs       <= {(2*IRAP_NUM_REGS){IRAP_REG_RESET}};
         r.spk_out    <= 1'b1;
         r.idle_high  <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // Outputs straight from the state register, except the IRQ12 lamp level tied low
   assign o_sd                           = r.sd_out;
   assign o_sd_oe                        = r.sd_oe;
   assign o_system_mgmt_interrupt_out_b  = r.idle_high;
   assign o_system_mgmt_interrupt_out_oe = r.strap_oe;
   assign o_speaker_out_pin_b            = r.spk_out;
   assign o_speaker_out_pin_oe           = r.strap_oe;
   assign o_ring_indicate_out_pin_b      = r.idle_high;
   assign o_ring_indicate_out_pin_oe     = r.strap_oe;
   assign o_irq12_lamp                   = 1'b0;
   assign o_irq12_lamp_oe                = r.lamp_oe;
   assign o_card_addr_hi                 = r.ca_hi;
   assign o_ata_mode                     = r.ata;
   assign o_power_down                   = r.power_down;

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   logic       slot_q;
   logic [5:0] reg_q;
   assign slot_q = slot;
   assign reg_q  = reg_no;

   sequence s_data_write;
      wr_start && is_data && claim && reg_ok;
   endsequence

   sequence s_held_write;
      (r.st == IRAP_ST_WRITE) && !i_iowr_b;
   endsequence

   a_index_write_takes: assert property (wr_start && !is_data |=> r.index == $past(i_sd))
      else $error("index port write not stored");

   a_data_write_store: assert property (s_data_write |=>
      r.regs[$past(slot_q)][$past(reg_q)] == $past(i_sd))
      else $error("data port write missed selected register");

   a_write_once_only: assert property (s_data_write ##1 s_held_write |=>
      $stable(r.regs))
      else $error("held write strobe wrote twice");

   a_read_data_drive: assert property (rd_start && is_data && claim |=>
      o_sd_oe && (o_sd == $past(rd_val)) && (r.st == IRAP_ST_READ))
      else $error("data port read not driven");

   a_unclaimed_float: assert property (rd_start && !claim |=> !o_sd_oe)
      else $error("unclaimed index read drove the bus");

   a_internal_addr: assert property (int_decode && !i_cs_b && !i_aen && !i_iowr_b &&
      (i_sa != IRAP_IO_INDEX) && (i_sa != IRAP_IO_DATA) && (r.st == IRAP_ST_IDLE) |=>
      $stable(r.index) && (r.st == IRAP_ST_IDLE))
      else $error("foreign address taken in internal decode");

   a_extern_cs_gate: assert property (!int_decode && i_cs_b && (r.st == IRAP_ST_IDLE)
      |=> $stable(r.index) && (r.st == IRAP_ST_IDLE))
      else $error("access taken without chip select");

   a_pd_ignore_bus: assert property (r.power_down |=> !o_sd_oe && $stable(r.index))
      else $error("bus not ignored in power-down");

   a_pd_both_slots: assert property (wr_start && is_data && claim &&
      (reg_no == IRAP_IDX_GLOBAL) |=> o_power_down == $past(i_sd[IRAP_PD_BIT]))
      else $error("power-down bit not written via global index");

   a_ata_addr_out: assert property (ata_en[0] && $stable(r.regs) |=>
      o_card_addr_hi[0] == $past(r.regs[0][IRAP_IDX_ATA][IRAP_CAHI_MSB:IRAP_CAHI_LSB]))
      else $error("ATA high address not from mode register");

   a_lamp_sink: assert property (lamp_mode[0] && !i_card_spkr_b[0] |=>
      o_irq12_lamp_oe &&
      (o_speaker_out_pin_b == $past(i_card_spkr_b[1] || lamp_mode[1])))
      else $error("lamp output wrong in ATA lamp mode");

   a_floppy_quiet: assert property ((r.st == IRAP_ST_IDLE) && !io_sel && floppy_addr &&
      !i_iord_b && ((i_card_io_hit & ~{r.regs[1][IRAP_IDX_ATA][IRAP_FLOPPY_BIT],
      r.regs[0][IRAP_IDX_ATA][IRAP_FLOPPY_BIT]}) == 2'b00) |=> !o_sd_oe)
      else $error("bus driven on guarded floppy read");

   a_card_window: assert property ((r.st == IRAP_ST_IDLE) && !r.power_down &&
      !wr_start && !rd_start && card_drive |=> o_sd_oe && (o_sd == $past(i_card_rd_data)))
      else $error("card window read not returned");

   a_ata_mode_out: assert property (1'b1 |=> o_ata_mode == $past(ata_en))
      else $error("ATA mode output not from mode register");

   a_high_reg_zero: assert property (rd_start && is_data && claim && !reg_ok |=>
      o_sd_oe && (o_sd == 8'h00))
      else $error("register past the last one read non-zero");

   a_dev_bit_gate: assert property (wr_start && is_data &&
      (r.index[IRAP_DEV_POS] != dev_bit) |=> $stable(r.regs) && $stable(r.power_down))
      else $error("data write taken for another device");

   a_read_release: assert property ((r.st == IRAP_ST_READ) && i_iord_b |=>
      !o_sd_oe && (r.st == IRAP_ST_IDLE))
      else $error("read data held after strobe release");

endmodule
`default_nettype wire

// ==== tb/irap_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ISA host stand-in: single 8-bit I/O cycles, plus the board straps on the shared pins
module irap_host_model (
   input  wire logic        i_clk,
   input  wire logic [7:0]  i_sd,
   input  wire logic        i_sd_oe,
   input  wire logic [2:0]  i_pin_b,
   input  wire logic [2:0]  i_pin_oe,
   input  wire logic [2:0]  i_pull,
   output logic [15:0]      o_sa,
   output logic [7:0]       o_sd,
   output logic             o_iord_b,
   output logic             o_iowr_b,
   output logic             o_aen,
   output logic             o_cs_b,
   output logic [2:0]       o_pin_b,
   output logic             o_done,
   output logic             o_oe,
   output logic [7:0]       o_data
);
   // Weak pulls win only while the device leaves a pin undriven
   assign o_pin_b = (i_pin_oe & i_pin_b) | (~i_pin_oe & i_pull);

   initial begin
      o_sa = 16'h0000;
      o_sd = 8'h00;
      o_iord_b = 1'b1;
      o_iowr_b = 1'b1;
      o_aen = 1'b0;
      o_cs_b = 1'b1;
      o_done = 1'b0;
      o_oe = 1'b0;
      o_data = 8'h00;
   end

   // Write cycle; released lines show the inverse so stale values never pass
   task automatic io_wr(input logic [15:0] a, input logic [7:0] d, input logic cs);
      @(posedge i_clk);
      o_sa <= a;
      o_sd <= d;
      o_cs_b <= cs;
      o_iowr_b <= 1'b0;
      repeat (2) @(posedge i_clk);
      o_iowr_b <= 1'b1;
      o_cs_b <= 1'b1;
      o_sa <= ~a;
      o_sd <= ~d;
      @(posedge i_clk);
   endtask

   // Read cycle; data taken at the edge that also releases the strobe
   task automatic io_rd(input logic [15:0] a, input logic cs);
      @(posedge i_clk);
      o_sa <= a;
      o_cs_b <= cs;
      o_iord_b <= 1'b0;
      repeat (3) @(posedge i_clk);
      o_oe <= i_sd_oe;
      o_data <= i_sd;
      o_done <= 1'b1;
      o_iord_b <= 1'b1;
      o_cs_b <= 1'b1;
      o_sa <= ~a;
      @(posedge i_clk);
      o_done <= 1'b0;
      @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   import irap_pkg::*;
   logic             clk = 1'b0;
   logic             rst_b, resetdrv;
   logic [1:0]       hit, spkr;
   logic [7:0]       cdata, v, idx;
   logic [1:0][4:0]  mapca;
   logic [2:0]       pull;
   logic [31:0]      rnd;
   logic [7:0]       vs [2];
   logic [8:0]       exp_q [$];
   int               tests_run = 0, mismatches = 0, cycles = 0;
   wire  [15:0]      sa;
   wire  [7:0]       sd_in, sd_out, rdata;
   wire              iord_b, iowr_b, aen, cs_b, sd_oe, done, roe, lamp, lamp_oe, pd;
   wire  [2:0]       pin_in, pin_out, pin_oe;
   wire  [1:0][4:0]  ca_hi;
   wire  [1:0]       ata;

   always #12.5 clk = ~clk;

   irap_top #(.P_ONE_SLOT(1'b0)) u_irap_top (.i_clk(clk), .i_rst_b(rst_b),
      .i_resetdrv(resetdrv), .i_sa(sa), .i_sd(sd_in), .i_iord_b(iord_b), .i_iowr_b(iowr_b),
      .i_aen(aen), .i_cs_b(cs_b), .i_card_io_hit(hit), .i_card_rd_data(cdata),
      .i_map_ca_hi(mapca), .i_card_spkr_b(spkr), .i_system_mgmt_interrupt_out_b(pin_in[2]),
      .i_speaker_out_pin_b(pin_in[1]), .i_ring_indicate_out_pin_b(pin_in[0]), .o_sd(sd_out),
      .o_sd_oe(sd_oe), .o_system_mgmt_interrupt_out_b(pin_out[2]),
      .o_system_mgmt_interrupt_out_oe(pin_oe[2]), .o_speaker_out_pin_b(pin_out[1]),
      .o_speaker_out_pin_oe(pin_oe[1]), .o_ring_indicate_out_pin_b(pin_out[0]),
      .o_ring_indicate_out_pin_oe(pin_oe[0]), .o_irq12_lamp(lamp), .o_irq12_lamp_oe(lamp_oe),
      .o_card_addr_hi(ca_hi), .o_ata_mode(ata), .o_power_down(pd));

   irap_host_model u_irap_host_model (.i_clk(clk), .i_sd(sd_out), .i_sd_oe(sd_oe),
      .i_pin_b(pin_out), .i_pin_oe(pin_oe), .i_pull(pull), .o_sa(sa), .o_sd(sd_in),
      .o_iord_b(iord_b), .o_iowr_b(iowr_b), .o_aen(aen), .o_cs_b(cs_b), .o_pin_b(pin_in),
      .o_done(done), .o_oe(roe), .o_data(rdata));

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic complete_run();
      $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // A floating expectation (top bit clear) only demands the bus left undriven
   task automatic chk_rd(input logic [8:0] e, input logic [8:0] g);
      tests_run++;
      if (e[8] === 1'b0 ? g[8] !== 1'b0 : g !== e) begin
         mismatches++;
         $display("CHECK FAILED read expected %h seen %h", e, g);
      end
   endtask

   task automatic chk_sig(input string what, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      u_irap_host_model.io_wr(a, d, 1'b0);
   endtask

   task automatic rd(input logic [15:0] a, input logic [8:0] e, input logic cs);
      exp_q.push_back(e);
      u_irap_host_model.io_rd(a, cs);
   endtask

   // Straps are pulled while reset drive is high, then latched on its fall
   task automatic rst(input logic [2:0] p);
      @(posedge clk);
      rst_b <= 1'b0;
      resetdrv <= 1'b1;
      pull <= p;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      resetdrv <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // Each finished read is matched against the oldest note
   always @(posedge clk) begin
      if (done === 1'b1) begin
         if (exp_q.size() == 0) begin
            mismatches++;
            $display("CHECK FAILED queue expected note seen none");
         end else begin
            chk_rd(exp_q.pop_front(), {roe, rdata});
         end
      end
   end

   // Guard against a hung handshake; the whole run needs well under this
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         complete_run();
      end
   end

   initial begin
      rst_b = 1'b0;
      resetdrv = 1'b1;
      hit = 2'h0;
      spkr = 2'h3;
      cdata = 8'h00;
      mapca = '0;
      pull = 3'h5;
      rnd = 32'hB705A782;
      rst(3'h5);
      wr(IRAP_IO_INDEX, 8'h9F);
      rd(IRAP_IO_DATA, 9'h100, 1'b0);
      for (int s = 0; s < 2; s++) begin
         rnd = nxt(rnd);
         v = {1'b0, rnd[6:0]};
         idx = {1'b1, s[0], 6'h1F};
         mapca <= {rnd[20:16], rnd[14:10]};
         wr(IRAP_IO_INDEX, idx);
         wr(IRAP_IO_DATA, v);
         rd(IRAP_IO_DATA, {1'b1, v}, 1'b0);
         rd(IRAP_IO_INDEX, {1'b1, idx}, 1'b0);
         repeat (2) @(posedge clk);
         chk_sig("ata_mode", {7'h00, v[0]}, {7'h00, ata[s]});
         chk_sig("card_addr", {3'h0, v[0] ? v[6:2] : mapca[s]}, {3'h0, ca_hi[s]});
         vs[s] = v;
      end
      $display("test register access done");
      wr(IRAP_IO_INDEX, 8'h1F);
      wr(IRAP_IO_DATA, 8'h55);
      rd(IRAP_IO_DATA, 9'h000, 1'b0);
      rd(IRAP_IO_INDEX, 9'h000, 1'b0);
      wr(IRAP_IO_INDEX, 8'hF0);
      rd(IRAP_IO_DATA, 9'h000, 1'b0);
      wr(IRAP_IO_INDEX, 8'hB8);
      wr(IRAP_IO_DATA, 8'hA5);
      rd(IRAP_IO_DATA, 9'h100, 1'b0);
      wr(IRAP_IO_INDEX, 8'h9F);
      rd(IRAP_IO_DATA, {1'b1, vs[0]}, 1'b0);
      rd(16'h03E2, 9'h000, 1'b0);
      wr(16'h03E2, 8'h00);
      rd(IRAP_IO_INDEX, {1'b1, 8'h9F}, 1'b0);
      rd(IRAP_IO_DATA, 9'h000, 1'b1);
      $display("test index ranges done");
      spkr <= 2'h2;
      wr(IRAP_IO_DATA, 8'h01);
      repeat (2) @(posedge clk);
      chk_sig("speaker_out", 8'h00, {7'h00, pin_out[1]});
      chk_sig("lamp_oe", 8'h00, {7'h00, lamp_oe});
      wr(IRAP_IO_DATA, 8'h03);
      repeat (2) @(posedge clk);
      chk_sig("speaker_out", 8'h01, {7'h00, pin_out[1]});
      chk_sig("lamp_oe", 8'h01, {7'h00, lamp_oe});
      chk_sig("lamp_level", 8'h00, {7'h00, lamp});
      rnd = nxt(rnd);
      cdata <= rnd[7:0];
      hit <= 2'h1;
      wr(IRAP_IO_DATA, 8'h01);
      rd(IRAP_IO_FLOPPY_A, {1'b1, rnd[7:0]}, 1'b0);
      wr(IRAP_IO_DATA, 8'h81);
      rd(IRAP_IO_FLOPPY_A, 9'h000, 1'b0);
      rd(IRAP_IO_FLOPPY_B, 9'h000, 1'b0);
      hit <= 2'h0;
      $display("test ata mode done");
      wr(IRAP_IO_INDEX, 8'hDE);
      wr(IRAP_IO_DATA, 8'h01);
      repeat (2) @(posedge clk);
      chk_sig("power_down", 8'h01, {7'h00, pd});
      rd(IRAP_IO_DATA, 9'h000, 1'b0);
      $display("test power down done");
      rst(3'h3);
      rnd = nxt(rnd);
      wr(16'h0240, 8'h1F);
      wr(16'h0241, rnd[7:0]);
      rd(16'h0241, {1'b1, rnd[7:0]}, 1'b0);
      rd(16'h0241, 9'h000, 1'b1);
      u_irap_host_model.io_wr(16'h0240, 8'h00, 1'b1);
      rd(16'h0240, 9'h11F, 1'b0);
      repeat (2) @(posedge clk);
      $display("test external decode done");
      complete_run();
   end
endmodule
`default_nettype wire
